// File: ams_defs.svh
// Functional notes
// - reset from power-on, pin, or command
// - any reset loads defaults, idles low-power
// - hold power-on reset about 500 us
// - both reset codes give full reset
// - general-call software reset also resets
// - single-shot: one conversion per start
// - single-shot idle: oscillator, analog off
// - single-shot config write restarts conversion
// - continuous: load result, begin next
// - start delay 28.5 or 105 clocks
// - continuous config write restarts conversion
// - sleep finishes conversion, then powers down
// - power-down keeps settings, answers commands
// - start in power-down wakes device
// - normal: modulator at 256 kHz default
// - turbo: modulator at 512 kHz
// - address is 100, high strap, low
// - straps resampled between start, first fall
// - slave only, lines driven low only
// - start and sleep command byte codes
// - commands act once latched
`ifndef AMS_DEFS_SVH
`define AMS_DEFS_SVH

`define AMS_CLK_HZ           64'd20000000
`define AMS_POR_HOLD_US      64'd500
`define AMS_POR_HOLD_CYC     ((`AMS_POR_HOLD_US * `AMS_CLK_HZ + 64'd999999) / 64'd1000000)
`define AMS_SYSCLK_NORM_HZ   64'd1024000
`define AMS_SYSCLK_TURBO_HZ  64'd2048000
`define AMS_START_NORM_X10   64'd285
`define AMS_START_TURBO_X10  64'd1050
`define AMS_START_NORM_CYC   ((`AMS_START_NORM_X10 * `AMS_CLK_HZ + 64'd10 * `AMS_SYSCLK_NORM_HZ - 64'd1) / (64'd10 * `AMS_SYSCLK_NORM_HZ))
`define AMS_START_TURBO_CYC  ((`AMS_START_TURBO_X10 * `AMS_CLK_HZ + 64'd10 * `AMS_SYSCLK_TURBO_HZ - 64'd1) / (64'd10 * `AMS_SYSCLK_TURBO_HZ))
`define AMS_MOD_NORM_HZ      64'd256000
`define AMS_MOD_TURBO_HZ     64'd512000
`define AMS_MOD_NORM_DIV     (`AMS_CLK_HZ / `AMS_MOD_NORM_HZ)
`define AMS_MOD_TURBO_DIV    (`AMS_CLK_HZ / `AMS_MOD_TURBO_HZ)
`define AMS_CMD_START        7'h04
`define AMS_CMD_SLEEP        7'h01
`define AMS_CMD_RESET        7'h03
`define AMS_ADDR_PREFIX      3'h4

`endif

// File: ams_pkg.sv
package ams_pkg;

  typedef enum logic [2:0] {
    AMS_POR_HOLD   = 3'h0,
    AMS_DEFAULTS   = 3'h1,
    AMS_LOW_POWER  = 3'h2,
    AMS_START_WAIT = 3'h3,
    AMS_CONVERT    = 3'h4,
    AMS_POWER_DOWN = 3'h5
  } ams_state_type;

endpackage : ams_pkg

// File: ams_sync.sv
`timescale 1ns/1ns
module ams_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : ams_sync

// File: ams_tick_div.sv
`timescale 1ns/1ns
`include "ams_defs.svh"
module ams_tick_div (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic turbo,
  output logic      tick
);
  localparam logic [6:0] NORM_DIV  = 7'(`AMS_MOD_NORM_DIV);
  localparam logic [6:0] TURBO_DIV = 7'(`AMS_MOD_TURBO_DIV);

  logic [6:0] count;
  logic [6:0] limit;

  // turbo doubles the modulator rate by halving the divide
  assign limit = turbo ? TURBO_DIV : NORM_DIV;

  // divider stops with the oscillator so no ticks leak into idle
  always_ff @(posedge clk) begin
    if (!rst_n || !enable) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (count == limit - 7'h01) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick  <= 1'b0;
    end
  end
endmodule : ams_tick_div

// File: ams_mode_sequencer.sv
`timescale 1ns/1ns
`include "ams_defs.svh"
module ams_mode_sequencer #(
  parameter int POR_HOLD_CYCLES = int'(`AMS_POR_HOLD_CYC)
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reset_pin_n,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       gencall_reset,
  input  wire logic       cfg_write,
  input  wire logic       conversion_mode_select_bit,
  input  wire logic       turbo_mode,
  input  wire logic [2:0] data_rate_field,
  input  wire logic       excitation_current_source_request,
  input  wire logic       conv_done,
  input  wire logic       start_cond,
  input  wire logic       first_scl_fall,
  input  wire logic [1:0] addr_strap_high,
  input  wire logic [1:0] addr_strap_low,
  input  wire logic       sda_in,
  input  wire logic       sda_pull_low,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [6:0]      slave_addr,
  output logic            cfg_defaults_load,
  output logic            osc_enable,
  output logic            analog_enable,
  output logic            ref_enable,
  output logic            excitation_current_source_enable,
  output logic            conv_start,
  output logic            conv_active,
  output logic            result_load,
  output logic            mod_clk_en,
  output logic [2:0]      active_rate,
  output ams_pkg::ams_state_type mode_state
);
  import ams_pkg::*;

  localparam logic [10:0] START_NORM  = 11'(`AMS_START_NORM_CYC);
  localparam logic [10:0] START_TURBO = 11'(`AMS_START_TURBO_CYC);
  localparam logic [15:0] POR_LAST    = 16'(POR_HOLD_CYCLES - 1);

  ams_state_type state;
  ams_state_type next_state;
  logic [15:0]   por_cnt;
  logic [10:0]   wait_cnt;
  logic [10:0]   wait_target;
  logic          pin_n_sync;
  logic [3:0]    strap_sync;
  logic          addr_window;
  logic          mode_cont;
  logic          turbo_lat;
  logic          sleep_pending;
  logic          cmd_start;
  logic          cmd_sleep;
  logic          any_reset;
  logic          restart;
  logic          next_conv_start;
  logic          next_result_load;

  // reset pin and straps arrive from outside the clock domain
  ams_sync #(.WIDTH(1)) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (reset_pin_n),
    .sync_out (pin_n_sync)
  );

  ams_sync #(.WIDTH(4)) u_strap_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({addr_strap_high, addr_strap_low}),
    .sync_out (strap_sync)
  );

  // modulator enable pulses only while the oscillator runs
  ams_tick_div u_mod_div (
    .clk    (clk),
    .rst_n  (rst_n),
    .enable (osc_enable),
    .turbo  (turbo_lat),
    .tick   (mod_clk_en)
  );

  // command decode, low bit is a don't-care; acted on only when latched
  assign cmd_start = cmd_valid && (cmd_byte[7:1] == `AMS_CMD_START);
  assign cmd_sleep = cmd_valid && (cmd_byte[7:1] == `AMS_CMD_SLEEP);
  // pin, reset command (both codes) and general call all reset alike
  assign any_reset = !pin_n_sync || gencall_reset
                     || (cmd_valid && (cmd_byte[7:1] == `AMS_CMD_RESET));
  // config write during a conversion behaves as a fresh start
  assign restart   = cmd_start || (cfg_write && (state == AMS_START_WAIT
                     || state == AMS_CONVERT));
  assign wait_target = turbo_lat ? START_TURBO : START_NORM;

  // next-state selection; reset beats start, start beats completion
  always_comb begin
    next_state       = state;
    next_conv_start  = 1'b0;
    next_result_load = 1'b0;
    case (state)
      AMS_POR_HOLD: begin
        if (por_cnt == POR_LAST) begin
          next_state = AMS_DEFAULTS;
        end
      end
      AMS_DEFAULTS: begin
        // a reset landing here reloads defaults once more instead of being lost
        if (!any_reset) begin
          next_state = AMS_LOW_POWER;
        end
      end
      AMS_LOW_POWER, AMS_POWER_DOWN: begin
        if (any_reset) begin
          next_state = AMS_DEFAULTS;
        end else if (cmd_start) begin
          next_state = AMS_START_WAIT;
        end else if (cmd_sleep) begin
          next_state = AMS_POWER_DOWN;
        end
      end
      AMS_START_WAIT: begin
        if (any_reset) begin
          next_state = AMS_DEFAULTS;
        end else if (restart) begin
          next_state = AMS_START_WAIT;
        end else if (cmd_sleep || sleep_pending) begin
          next_state = AMS_POWER_DOWN; // nothing running yet to finish
        end else if (wait_cnt == wait_target - 11'h002) begin
          next_state      = AMS_CONVERT;
          next_conv_start = 1'b1;
        end
      end
      AMS_CONVERT: begin
        if (any_reset) begin
          next_state = AMS_DEFAULTS;
        end else if (restart) begin
          next_state = AMS_START_WAIT;
        end else if (conv_done) begin
          next_result_load = 1'b1;
          if (cmd_sleep || sleep_pending) begin
            next_state = AMS_POWER_DOWN;
          end else if (mode_cont) begin
            next_state      = AMS_CONVERT;
            next_conv_start = 1'b1;
          end else begin
            next_state = AMS_LOW_POWER;
          end
        end
      end
      default: begin
        next_state = AMS_DEFAULTS;
      end
    endcase
  end

  // state register; power-on reset restarts the hold count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= AMS_POR_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // power-on hold counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      por_cnt <= 16'h0000;
    end else if (state == AMS_POR_HOLD) begin
      por_cnt <= por_cnt + 16'h0001;
    end
  end

  // start delay counter, cleared on every fresh start
  always_ff @(posedge clk) begin
    if (!rst_n || next_state != AMS_START_WAIT || state != AMS_START_WAIT || restart) begin
      wait_cnt <= 11'h000;
    end else begin
      wait_cnt <= wait_cnt + 11'h001;
    end
  end

  // mode, speed and rate captured at start; later changes wait for a start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_cont   <= 1'b0;
      turbo_lat   <= 1'b0; // normal mode after power-up
      active_rate <= 3'h0;
    end else if (next_state == AMS_DEFAULTS) begin
      mode_cont   <= 1'b0;
      turbo_lat   <= 1'b0;
      active_rate <= 3'h0;
    end else if (restart && state != AMS_POR_HOLD && state != AMS_DEFAULTS) begin
      mode_cont   <= conversion_mode_select_bit;
      turbo_lat   <= turbo_mode;
      active_rate <= data_rate_field;
    end
  end

  // sleep waits for the running conversion; the reset and power-down clear wins over a late sleep
  always_ff @(posedge clk) begin
    if (!rst_n || next_state == AMS_DEFAULTS || next_state == AMS_POWER_DOWN) begin
      sleep_pending <= 1'b0;
    end else if (cmd_sleep) begin
      sleep_pending <= 1'b1;
    end else if (cmd_start) begin
      sleep_pending <= 1'b0;
    end
  end

  // power and strobe outputs, registered from the next state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_defaults_load <= 1'b0;
      osc_enable        <= 1'b0;
      analog_enable     <= 1'b0;
      ref_enable        <= 1'b0;
      excitation_current_source_enable       <= 1'b0;
      conv_start        <= 1'b0;
      conv_active       <= 1'b0;
      result_load       <= 1'b0;
    end else begin
      cfg_defaults_load <= (next_state == AMS_DEFAULTS);
      osc_enable        <= (next_state == AMS_START_WAIT) || (next_state == AMS_CONVERT);
      analog_enable     <= (next_state == AMS_START_WAIT) || (next_state == AMS_CONVERT);
      ref_enable        <= (next_state == AMS_START_WAIT) || (next_state == AMS_CONVERT);
      // excitation stays up in single-shot idle, drops in power-down
      excitation_current_source_enable       <= excitation_current_source_request && (next_state == AMS_LOW_POWER
                           || next_state == AMS_START_WAIT || next_state == AMS_CONVERT);
      conv_start        <= next_conv_start;
      conv_active       <= (next_state == AMS_CONVERT);
      result_load       <= next_result_load;
    end
  end

  // strap window opens at START and closes on the first address-byte fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_window <= 1'b0;
    end else if (start_cond) begin
      addr_window <= 1'b1;
    end else if (first_scl_fall) begin
      addr_window <= 1'b0;
    end
  end

  // address resampled each transaction; decode uses the last value seen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slave_addr <= {`AMS_ADDR_PREFIX, 4'h0};
    end else if (start_cond || addr_window) begin
      slave_addr <= {`AMS_ADDR_PREFIX, strap_sync};
    end
  end

  // open-drain data: only ever pulls low, clock line is never driven
  assign sda_out = 1'b0;
  assign sda_oe  = sda_pull_low;
  assign mode_state = state;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_quiet;
    !any_reset && !cmd_valid && !cfg_write;
  endsequence

  sequence s_done_single;
    state == AMS_CONVERT && conv_done && !mode_cont && !sleep_pending ##0 s_quiet;
  endsequence

  a_por_hold_len: assert property (state == AMS_POR_HOLD && por_cnt < POR_LAST |=> state == AMS_POR_HOLD)
    else $error("power-on hold ended early");
  a_start_delay: assert property (state == AMS_START_WAIT && next_state == AMS_CONVERT
    |-> wait_cnt == wait_target - 11'h002 ##1 conv_start)
    else $error("conversion began at wrong delay");
  a_single_return: assert property (s_done_single |=> state == AMS_LOW_POWER && result_load && !osc_enable)
    else $error("single conversion did not return to idle");
  a_cont_next: assert property (state == AMS_CONVERT && conv_done && mode_cont && !sleep_pending ##0 s_quiet
    |=> result_load && conv_start && conv_active)
    else $error("continuous conversion did not chain");
  a_sleep_finish: assert property (state == AMS_CONVERT && cmd_sleep && !conv_done && !any_reset && !cfg_write
    |=> state == AMS_CONVERT)
    else $error("sleep cut a conversion short");
  a_sleep_command_off: assert property (state == AMS_POWER_DOWN ##1 state == AMS_POWER_DOWN
    |-> !analog_enable && !ref_enable && !excitation_current_source_enable && !conv_active)
    else $error("analog left on in power-down");
  a_cfg_restart: assert property (state == AMS_CONVERT && cfg_write && !any_reset |=> state == AMS_START_WAIT)
    else $error("config write did not restart");
  a_reset_cmd: assert property (state != AMS_POR_HOLD && any_reset |=> state == AMS_DEFAULTS && cfg_defaults_load)
    else $error("reset did not load defaults");
  a_wake_start: assert property (state == AMS_POWER_DOWN && cmd_start && !any_reset |=> state == AMS_START_WAIT)
    else $error("start did not wake device");
  a_addr_form: assert property (start_cond |=> slave_addr == {`AMS_ADDR_PREFIX, $past(strap_sync)})
    else $error("slave address not formed from straps");
  a_sda_low: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data line driven high");
endmodule : ams_mode_sequencer

// File: ams_host_model.sv
`timescale 1ns/1ns
module ams_host_model #(
  parameter int RESET_TO_COMM_CYCLES = 6
) (
  input  wire logic       clk,
  input  wire logic [2:0] op,
  input  wire logic [7:0] op_arg,
  output logic            busy,
  output logic            reset_pin_n    = 1'b1,
  output logic            cmd_valid      = 1'b0,
  output logic [7:0]      cmd_byte       = 8'hFF,
  output logic            gencall_reset  = 1'b0,
  output logic            cfg_write      = 1'b0,
  output logic            start_cond     = 1'b0,
  output logic            first_scl_fall = 1'b0,
  output logic            sda_pull_low   = 1'b0
);
  logic [7:0] low_cnt   = 8'h00;
  int         quiet_cnt = 0;

  // host may not talk while the pin is low or during its recovery time
  assign busy = !reset_pin_n || quiet_cnt != 0;

  // ops: 1 command byte, 2 general call, 3 config write, 4 start, 5 first scl fall,
  // 6 pin reset for op_arg cycles, 7 sda pull set to op_arg bit 0; strobes stand one cycle
  always @(posedge clk) begin
    cmd_valid      <= (op == 3'h1);
    gencall_reset  <= (op == 3'h2);
    cfg_write      <= (op == 3'h3);
    start_cond     <= (op == 3'h4);
    first_scl_fall <= (op == 3'h5);
    // released lane shows the inverse so stale data never matches
    if (op == 3'h1) begin
      cmd_byte <= op_arg;
    end else if (cmd_valid) begin
      cmd_byte <= ~cmd_byte;
    end
    if (op == 3'h7) begin
      sda_pull_low <= op_arg[0];
    end
    // pin held low for the asked cycles, then quiet before talking again
    if (op == 3'h6) begin
      reset_pin_n <= 1'b0;
      low_cnt     <= op_arg - 8'h01;
    end else if (!reset_pin_n) begin
      if (low_cnt == 8'h00) begin
        reset_pin_n <= 1'b1;
        quiet_cnt   <= RESET_TO_COMM_CYCLES;
      end else begin
        low_cnt <= low_cnt - 8'h01;
      end
    end else if (quiet_cnt != 0) begin
      quiet_cnt <= quiet_cnt - 1;
    end
  end
endmodule : ams_host_model

// File: ams_mode_sequencer_tb.sv
`timescale 1ns/1ns
module ams_mode_sequencer_tb;
  import ams_pkg::*;
  localparam int POR_CYC = 20;
  logic clk, rst_n, conv_done, cm, turbo, excitation_current_source_req, sda_in;
  logic [2:0] rate;
  logic [1:0] strap_h, strap_l;
  logic reset_pin_n, cmd_valid, gencall_reset, cfg_write, start_cond, first_scl_fall, sda_pull_low;
  logic [7:0] cmd_byte;
  logic [2:0] host_op;
  logic [7:0] host_arg;
  logic host_busy;
  localparam logic [2:0] OP_CMD = 3'h1, OP_GCALL = 3'h2, OP_CFG = 3'h3, OP_START = 3'h4;
  localparam logic [2:0] OP_FALL = 3'h5, OP_PIN = 3'h6, OP_SDA = 3'h7;
  logic sda_out, sda_oe, cfg_defaults_load, osc_enable, analog_enable, ref_enable, excitation_current_source_enable;
  logic conv_start, conv_active, result_load, mod_clk_en;
  logic [6:0] slave_addr;
  logic [2:0] active_rate;
  ams_state_type mode_state;
  int n_errors = 0;
  int compares = 0;

  // open-drain data line with pull-up
  assign sda_in = (sda_oe === 1'b1) ? sda_out : 1'b1;

  ams_host_model u_ams_host_model (.clk(clk), .op(host_op), .op_arg(host_arg), .busy(host_busy),
    .reset_pin_n(reset_pin_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .gencall_reset(gencall_reset),
    .cfg_write(cfg_write), .start_cond(start_cond), .first_scl_fall(first_scl_fall),
    .sda_pull_low(sda_pull_low));

  ams_mode_sequencer #(.POR_HOLD_CYCLES(POR_CYC)) u_ams_mode_sequencer (.clk(clk), .rst_n(rst_n),
    .reset_pin_n(reset_pin_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .gencall_reset(gencall_reset),
    .cfg_write(cfg_write), .conversion_mode_select_bit(cm), .turbo_mode(turbo), .data_rate_field(rate),
    .excitation_current_source_request(excitation_current_source_req), .conv_done(conv_done), .start_cond(start_cond), .first_scl_fall(first_scl_fall),
    .addr_strap_high(strap_h), .addr_strap_low(strap_l), .sda_in(sda_in), .sda_pull_low(sda_pull_low),
    .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr(slave_addr), .cfg_defaults_load(cfg_defaults_load),
    .osc_enable(osc_enable), .analog_enable(analog_enable), .ref_enable(ref_enable),
    .excitation_current_source_enable(excitation_current_source_enable), .conv_start(conv_start), .conv_active(conv_active),
    .result_load(result_load), .mod_clk_en(mod_clk_en), .active_rate(active_rate), .mode_state(mode_state));

  // 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // hand one request to the host; returns just after the edge at which the block samples it
  task automatic host(input logic [2:0] k, input logic [7:0] arg);
    @(posedge clk);
    host_op  <= k;
    host_arg <= arg;
    @(posedge clk);
    host_op  <= 3'h0;
    @(posedge clk);
    #1;
  endtask : host

  // pin reset, then wait out the host's recovery time; bounded
  task automatic pin_reset(input int low);
    int n;
    n = 0;
    host(OP_PIN, 8'(low));
    while (host_busy === 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    chk("pin_recovery", 0, host_busy);
  endtask : pin_reset

  // counts from the edge that took the request; bounded so a lost start cannot hang
  task automatic wait_start(input int exp);
    int n;
    n = 1;
    while (conv_start !== 1'b1 && n < 1200) begin
      step(1);
      n++;
    end
    chk("start_delay", exp, n);
  endtask : wait_start

  task automatic mod_gap(input int exp);
    int n, k;
    n = 0;
    k = 0;
    while (k < 2 && n < 200) begin
      step(1);
      n++;
      if (mod_clk_en === 1'b1) begin
        k++;
        if (k == 1) n = 0;
      end
    end
    chk("mod_gap", exp, n);
  endtask : mod_gap

  task automatic done_pulse;
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    #1;
  endtask : done_pulse

  task automatic t_power_up;
    int n;
    n = 0;
    while (mode_state !== AMS_LOW_POWER && n < 100) begin
      step(1);
      n++;
    end
    chk("por_long_enough", 1, n >= POR_CYC);
    chk("state", AMS_LOW_POWER, mode_state);
    chk("osc_enable", 0, osc_enable);
    chk("excitation_current_source_enable", 1, excitation_current_source_enable);
    chk("slave_addr", 7'h40, slave_addr);
    @(posedge clk);
    excitation_current_source_req <= 1'b0;
    step(2);
    chk("excitation_current_source_enable", 0, excitation_current_source_enable);
    @(posedge clk);
    excitation_current_source_req <= 1'b1;
    step(2);
    chk("excitation_current_source_enable", 1, excitation_current_source_enable);
  endtask : t_power_up

  task automatic t_single;
    host(OP_CMD, 8'h08);
    #1;
    chk("state", AMS_START_WAIT, mode_state);
    wait_start(557);
    chk("active_rate", 3'h5, active_rate);
    mod_gap(78);
    host(OP_CFG, 8'h00);
    #1;
    chk("state", AMS_START_WAIT, mode_state);
    wait_start(557);
    done_pulse;
    chk("result_load", 1, result_load);
    chk("state", AMS_LOW_POWER, mode_state);
    chk("osc_enable", 0, osc_enable);
    chk("analog_enable", 0, analog_enable);
    chk("excitation_current_source_enable", 1, excitation_current_source_enable);
    step(3);
    chk("conv_active", 0, conv_active);
  endtask : t_single

  task automatic t_cont;
    @(posedge clk);
    cm <= 1'b1;
    turbo <= 1'b1;
    rate <= 3'h6;
    host(OP_CMD, 8'h09);
    wait_start(1026);
    mod_gap(39);
    done_pulse;
    chk("result_load", 1, result_load);
    chk("conv_start", 1, conv_start);
    host(OP_CFG, 8'h00);
    #1;
    chk("state", AMS_START_WAIT, mode_state);
    wait_start(1026);
    host(OP_CMD, 8'h03);
    #1;
    chk("state", AMS_CONVERT, mode_state);
    done_pulse;
    chk("state", AMS_POWER_DOWN, mode_state);
    chk("ref_enable", 0, ref_enable);
    chk("excitation_current_source_enable", 0, excitation_current_source_enable);
    chk("analog_enable", 0, analog_enable);
    host(OP_CMD, 8'h12);
    step(2);
    chk("state", AMS_POWER_DOWN, mode_state);
    chk("active_rate", 3'h6, active_rate);
    @(posedge clk);
    cm <= 1'b0;
    turbo <= 1'b0;
    host(OP_CMD, 8'h08);
    #1;
    chk("state", AMS_START_WAIT, mode_state);
    wait_start(557);
  endtask : t_cont

  task automatic t_resets;
    host(OP_CMD, 8'h06);
    chk("state", AMS_DEFAULTS, mode_state);
    chk("conv_active", 0, conv_active);
    step(1);
    chk("state", AMS_LOW_POWER, mode_state);
    host(OP_CMD, 8'h08);
    host(OP_CMD, 8'h07);
    chk("state", AMS_DEFAULTS, mode_state);
    step(1);
    host(OP_CMD, 8'h08);
    host(OP_GCALL, 8'h06);
    chk("state", AMS_DEFAULTS, mode_state);
    step(1);
    host(OP_CMD, 8'h08);
    pin_reset(4);
    chk("state", AMS_LOW_POWER, mode_state);
    chk("osc_enable", 0, osc_enable);
  endtask : t_resets

  task automatic t_bus;
    logic [6:0] a;
    for (int h = 0; h < 4; h++) begin
      for (int l = 0; l < 4; l++) begin
        a = {3'b100, h[1:0], l[1:0]};
        @(posedge clk);
        strap_h <= h[1:0];
        strap_l <= l[1:0];
        step(3);
        host(OP_START, 8'h00);
        step(3);
        chk("slave_addr", a, slave_addr);
        host(OP_FALL, 8'h00);
        @(posedge clk);
        strap_h <= ~h[1:0];
        step(5);
        chk("slave_addr_held", a, slave_addr);
      end
    end
    host(OP_SDA, 8'h01);
    #1;
    chk("sda_oe", 1, sda_oe);
    chk("sda_line", 0, sda_in);
    host(OP_SDA, 8'h00);
    #1;
    chk("sda_oe", 0, sda_oe);
  endtask : t_bus

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done;
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    conv_done = 1'b0;
    cm = 1'b0;
    turbo = 1'b0;
    excitation_current_source_req = 1'b1;
    rate = 3'h5;
    strap_h = 2'h0;
    strap_l = 2'h0;
    host_op = 3'h0;
    host_arg = 8'h00;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_power_up;
    t_single;
    t_cont;
    t_resets;
    t_bus;
    test_done;
  end
endmodule : ams_mode_sequencer_tb
